// ---- shared/dsc_consts.svh ----
/*
 * Offsets, field positions, reset values and frame figures of the
 * driver status and control register bank.
 * Assumes it is included once per compile unit by its bare name.
 */
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// register offsets
`define DSC_ADDR_FAULT        5'h00
`define DSC_ADDR_OVERCURRENT  5'h01
`define DSC_ADDR_DIAG2        5'h02
`define DSC_ADDR_CTRL_FIRST   5'h03
`define DSC_ADDR_PROTECTION   5'h06
`define DSC_ADDR_CTRL_LAST    5'h08
`define DSC_ADDR_TORQUE_COUNT 5'h09

// fault summary bit positions
`define DSC_FLT_PIN    7
`define DSC_FLT_SPI    6
`define DSC_FLT_UV     5
`define DSC_FLT_PUMP_UNDERVOLTAGE_FLAG   4
`define DSC_FLT_OCP    3
`define DSC_FLT_STL    2
`define DSC_FLT_TF     1
`define DSC_FLT_OL     0

// second detail register bit positions
`define DSC_D2_UTW     7
`define DSC_D2_OTW     6
`define DSC_D2_OTS     5
`define DSC_D2_LEARN   4
`define DSC_D2_STALL   3
`define DSC_D2_RSVD    2
`define DSC_D2_OL_B    1
`define DSC_D2_OL_A    0

// control fields
`define DSC_TRQ_MSB        7
`define DSC_TRQ_LSB        4
`define DSC_SLEW_MSB       1
`define DSC_SLEW_LSB       0
`define DSC_CLEAR_FAULTS_BIT_BIT    7
`define DSC_MASK_FULL      8'hff
`define DSC_MASK_PROTECT   8'h7f

// control and status reset values, lowest offset in the low byte
`define DSC_RST_TORQUE_SLEW 8'h00
`define DSC_RST_DECAY       8'h00
`define DSC_RST_STEP_DIR    8'h00
`define DSC_RST_PROTECT     8'h00
`define DSC_RST_STALL_CFG   8'h00
`define DSC_RST_STALL_TH    8'h00
`define DSC_RST_STATUS      8'h00

// serial frame
`define DSC_FRAME_BITS  5'h10
`define DSC_ADDR_READY  5'h07
`define DSC_RW_BIT      14
`define DSC_ADDR_MSB    13
`define DSC_ADDR_LSB    9
`define DSC_STATUS_LEAD 2'h3

`endif

// ---- shared/dsc_pkg.sv ----
/*
 * Types of the driver status and control register bank.
 * Assumes the consts header is compiled alongside.
 */
package dsc_pkg;

    // raw detector levels from the analog core
    typedef struct packed {
        logic       supplyUndervoltageFlag;
        logic       pumpUndervoltageFlag;
        logic [7:0] bridgeOvercurrent;   // b_low2 .. a_high1
        logic       undertempWarningFlag;
        logic       overtempWarningFlag;
        logic       overtempShutdownFlag;
        logic       stallLearningDoneFlag;
        logic       stallFlag;
        logic       bridgeBOpenloadFlag;
        logic       bridgeAOpenloadFlag;
    } dsc_diag_t;

    // control register contents toward the driver core
    typedef struct packed {
        logic [3:0] torqueScaleField;
        logic [1:0] slewRate;
        logic [7:0] decayOfftime;
        logic [7:0] stepDirection;
        logic [7:0] protectionConfig;
        logic [7:0] stallConfig;
        logic [7:0] stallThreshold;
    } dsc_ctrl_t;

endpackage

// ---- rtl/dsc_ctrl_byte.sv ----
/*
 * One writable control byte with reset value and write mask.
 * Assumes writes arrive as single-cycle strobes on ref_clk.
 */
`timescale 1ns/100ps
module dsc_ctrl_byte
    import dsc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL  = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hff
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic       clear,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] value
);

    logic [7:0] next_value;

    // masked bits store zero, so self-clearing bits read back as 0
    always_comb begin
        next_value = value;
        if (clear) begin
            next_value = RESET_VAL & WRITE_MASK;
        end else if (wrEn) begin
            next_value = wrData & WRITE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            value <= RESET_VAL & WRITE_MASK;
        end else if (ce) begin
            value <= next_value;
        end
    end

endmodule

// ---- rtl/dsc_spi_frame.sv ----
/*
 * Serial frame engine: samples 16-bit frames, shifts out a status
 * byte and the addressed register's report byte, flags framing errors.
 * Assumes pins already synchronous to ref_clk, clock idles low.
 */
`timescale 1ns/100ps
`include "dsc_consts.svh"
module dsc_spi_frame
    import dsc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        chipSelectPin_n,
    input  wire logic        sclkPin,
    input  wire logic        sdiPin,
    input  wire logic [7:0]  statusByte,
    input  wire logic [7:0]  rdData,
    output logic      [4:0]  rdAddr,
    output logic             sdoPin,
    output logic             frameDone,
    output logic             frameErr,
    output logic      [15:0] frameWord
);

    typedef enum logic {FR_IDLE, FR_SHIFT} dsc_frame_state_t;

    dsc_frame_state_t state;
    dsc_frame_state_t next_state;
    logic [4:0]       cnt;
    logic [4:0]       next_cnt;
    logic [15:0]      rx;
    logic [15:0]      next_rx;
    logic [15:0]      tx;
    logic [15:0]      next_tx;
    logic             sclkPrev;
    logic             next_sclkPrev;
    logic             next_frameDone;
    logic             next_frameErr;
    logic [15:0]      next_frameWord;

    // address bits sit in the low rx bits just before the 8th edge
    assign rdAddr = rx[4:0];
    assign sdoPin = tx[15];

    // frame sequencing; count saturates one past a full frame
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_rx        = rx;
        next_tx        = tx;
        next_sclkPrev  = sclkPin;
        next_frameDone = 1'b0;
        next_frameErr  = 1'b0;
        next_frameWord = frameWord;
        case (state)
            FR_IDLE: begin
                if (!chipSelectPin_n) begin
                    next_state = FR_SHIFT;
                    next_cnt   = 5'h00;
                    next_tx    = {statusByte, 8'h00};
                end
            end
            FR_SHIFT: begin
                if (chipSelectPin_n) begin
                    next_state = FR_IDLE;
                    if (cnt == `DSC_FRAME_BITS) begin
                        next_frameDone = 1'b1;
                        next_frameWord = rx;
                    end else if (cnt == 5'h00 ||
                                 cnt > `DSC_FRAME_BITS) begin
                        next_frameErr = 1'b1;
                    end
                end else if (sclkPin && !sclkPrev) begin
                    next_rx = {rx[14:0], sdiPin};
                    if (cnt <= `DSC_FRAME_BITS) begin
                        next_cnt = 5'(cnt + 5'h01);
                    end
                    if (cnt == `DSC_ADDR_READY) begin
                        next_tx[14:7] = rdData;
                    end
                end else if (!sclkPin && sclkPrev && cnt != 5'h00) begin
                    next_tx = {tx[14:0], 1'b0};
                end
            end
            default: next_state = FR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state     <= FR_IDLE;
            cnt       <= 5'h00;
            rx        <= 16'h0000;
            tx        <= 16'h0000;
            sclkPrev  <= 1'b0;
            frameDone <= 1'b0;
            frameErr  <= 1'b0;
            frameWord <= 16'h0000;
        end else if (ce) begin
            state     <= next_state;
            cnt       <= next_cnt;
            rx        <= next_rx;
            tx        <= next_tx;
            sclkPrev  <= next_sclkPrev;
            frameDone <= next_frameDone;
            frameErr  <= next_frameErr;
            frameWord <= next_frameWord;
        end
    end

endmodule

// ---- rtl/dsc_regs.sv ----
/*
 * Driver status and first control register bank behind the serial
 * port: fault summary, detail registers, control bytes, fault pin.
 * Assumes detector levels and pins are synchronous to ref_clk.
 */
// Operation
// - fault summary bit 7 reads inverse of the fault indicator pin
// - over 16 clock rises or empty frame sets bit 6, drives fault pin
// - bit 5 reports supply undervoltage, bit 4 pump undervoltage
// - bit 3 any overcurrent, bit 2 stall, bit 0 open load
// - bit 1 is OR of both temperature warnings and shutdown
// - overcurrent byte: one flag per transistor, bridge A low nibble
// - detail byte bits 7..5: undertemp, overtemp warn, shutdown
// - detail bit 4 learning done, bit 3 stall detected
// - detail bit 1 open load B, bit 0 open load A, bit 2 zero
// - torque scale in bits 7..4 resets 0, reserved bits 3..2 reset 0
// - slew field in bits 1..0 resets 00, picks output edge rate
// - read report byte carries the addressed register's content
// - status bits are read-only and reset to zero
`timescale 1ns/100ps
`include "dsc_consts.svh"
module dsc_regs
    import dsc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic       sleepPin_n,
    input  wire logic       chipSelectPin_n,
    input  wire logic       sclkPin,
    input  wire logic       sdiPin,
    output logic            sdoPin,
    output logic            sdoOe,
    input  wire logic       faultIndicatorPinIn_n,
    output logic            faultIndicatorPinOut_n,
    output logic            faultIndicatorPinOe,
    input  wire dsc_diag_t  diag,
    input  wire logic [7:0] torqueCountIn,
    output dsc_ctrl_t       ctrl
);

    localparam int CTRL_N = 6;
    // reset values and write masks, offset 0x03 in the low byte
    localparam logic [8*CTRL_N-1:0] CTRL_RST = {
        `DSC_RST_STALL_TH, `DSC_RST_STALL_CFG, `DSC_RST_PROTECT,
        `DSC_RST_STEP_DIR, `DSC_RST_DECAY, `DSC_RST_TORQUE_SLEW};
    localparam logic [8*CTRL_N-1:0] CTRL_MASK = {
        `DSC_MASK_FULL, `DSC_MASK_FULL, `DSC_MASK_PROTECT,
        `DSC_MASK_FULL, `DSC_MASK_FULL, `DSC_MASK_FULL};

    dsc_diag_t  stat;
    dsc_diag_t  next_stat;
    logic [7:0] torqueCount;
    logic [7:0] next_torqueCount;
    logic       spiErr;
    logic       next_spiErr;
    logic       faultDrive;
    logic       next_faultDrive;

    logic [7:0]  ctrlVal [CTRL_N];
    logic [7:0]  faultByte;
    logic [7:0]  ocByte;
    logic [7:0]  diag2Byte;
    logic [7:0]  statusByte;
    logic [7:0]  rdData;
    logic [4:0]  rdAddr;
    logic        frameDone;
    logic        frameErr;
    logic [15:0] frameWord;
    logic        wrHit;
    logic [4:0]  wrAddr;
    logic [7:0]  wrData;
    logic        clrReq;
    logic        sleepClr;
    logic        faultAny;

    // serial engine
    dsc_spi_frame u_frame (
        .ref_clk         (ref_clk),
        .reset_n         (reset_n),
        .ce              (ce),
        .chipSelectPin_n (chipSelectPin_n),
        .sclkPin         (sclkPin),
        .sdiPin          (sdiPin),
        .statusByte      (statusByte),
        .rdData          (rdData),
        .rdAddr          (rdAddr),
        .sdoPin          (sdoPin),
        .frameDone       (frameDone),
        .frameErr        (frameErr),
        .frameWord       (frameWord)
    );

    // sdo only drives while selected, so daisy chains share the line
    assign sdoOe = !chipSelectPin_n;

    // decoded write from a complete frame
    assign wrHit    = frameDone && !frameWord[`DSC_RW_BIT];
    assign wrAddr   = frameWord[`DSC_ADDR_MSB:`DSC_ADDR_LSB];
    assign wrData   = frameWord[7:0];
    assign sleepClr = !sleepPin_n;
    assign clrReq   = sleepClr || (wrHit &&
                      wrAddr == `DSC_ADDR_PROTECTION &&
                      wrData[`DSC_CLEAR_FAULTS_BIT_BIT]);

    // control bytes 0x03..0x08; status offsets take no write
    for (genvar i = 0; i < CTRL_N; i++) begin : g_ctrl
        dsc_ctrl_byte #(
            .RESET_VAL  (CTRL_RST[8*i +: 8]),
            .WRITE_MASK (CTRL_MASK[8*i +: 8])
        ) u_byte (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .ce      (ce),
            .clear   (sleepClr),
            .wrEn    (wrHit && wrAddr == 5'(`DSC_ADDR_CTRL_FIRST + i)),
            .wrData  (wrData),
            .value   (ctrlVal[i])
        );
    end

    // control fields toward the core
    assign ctrl.torqueScaleField = ctrlVal[0][`DSC_TRQ_MSB:`DSC_TRQ_LSB];
    assign ctrl.slewRate         = ctrlVal[0][`DSC_SLEW_MSB:`DSC_SLEW_LSB];
    assign ctrl.decayOfftime     = ctrlVal[1];
    assign ctrl.stepDirection    = ctrlVal[2];
    assign ctrl.protectionConfig = ctrlVal[3];
    assign ctrl.stallConfig      = ctrlVal[4];
    assign ctrl.stallThreshold   = ctrlVal[5];

    // detector levels captured each cycle; host writes never reach them
    always_comb begin
        next_stat        = diag;
        next_torqueCount = torqueCountIn;
        if (sleepClr) begin
            next_stat        = '0;
            next_torqueCount = `DSC_RST_STATUS;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            stat        <= '0;
            torqueCount <= `DSC_RST_STATUS;
        end else if (ce) begin
            stat        <= next_stat;
            torqueCount <= next_torqueCount;
        end
    end

    // detail bytes
    assign ocByte = stat.bridgeOvercurrent;
    always_comb begin
        diag2Byte = 8'h00;
        diag2Byte[`DSC_D2_UTW]   = stat.undertempWarningFlag;
        diag2Byte[`DSC_D2_OTW]   = stat.overtempWarningFlag;
        diag2Byte[`DSC_D2_OTS]   = stat.overtempShutdownFlag;
        diag2Byte[`DSC_D2_LEARN] = stat.stallLearningDoneFlag;
        diag2Byte[`DSC_D2_STALL] = stat.stallFlag;
        diag2Byte[`DSC_D2_OL_B]  = stat.bridgeBOpenloadFlag;
        diag2Byte[`DSC_D2_OL_A]  = stat.bridgeAOpenloadFlag;
    end

    // fault summary; pin bit follows the pin, not our own drive
    always_comb begin
        faultByte = 8'h00;
        faultByte[`DSC_FLT_PIN]  = !faultIndicatorPinIn_n;
        faultByte[`DSC_FLT_SPI]  = spiErr;
        faultByte[`DSC_FLT_UV]   = stat.supplyUndervoltageFlag;
        faultByte[`DSC_FLT_PUMP_UNDERVOLTAGE_FLAG] = stat.pumpUndervoltageFlag;
        faultByte[`DSC_FLT_OCP]  = |stat.bridgeOvercurrent;
        faultByte[`DSC_FLT_STL]  = stat.stallFlag;
        faultByte[`DSC_FLT_TF]   = stat.undertempWarningFlag |
                                   stat.overtempWarningFlag |
                                   stat.overtempShutdownFlag;
        faultByte[`DSC_FLT_OL]   = stat.bridgeAOpenloadFlag |
                                   stat.bridgeBOpenloadFlag;
    end

    // status byte leads each frame; top bits fixed high as a sync mark
    assign statusByte = {`DSC_STATUS_LEAD, faultByte[5:0]};

    // read mux; unassigned offsets read as zero
    always_comb begin
        rdData = 8'h00;
        if (rdAddr == `DSC_ADDR_FAULT) begin
            rdData = faultByte;
        end else if (rdAddr == `DSC_ADDR_OVERCURRENT) begin
            rdData = ocByte;
        end else if (rdAddr == `DSC_ADDR_DIAG2) begin
            rdData = diag2Byte;
        end else if (rdAddr >= `DSC_ADDR_CTRL_FIRST &&
                     rdAddr <= `DSC_ADDR_CTRL_LAST) begin
            rdData = ctrlVal[3'(rdAddr - `DSC_ADDR_CTRL_FIRST)];
        end else if (rdAddr == `DSC_ADDR_TORQUE_COUNT) begin
            rdData = torqueCount;
        end
    end

    // protocol error latch; a new error wins over a clear in one cycle.
    // clearing waits for deselect so a clear inside a bad frame is moot
    assign faultAny = spiErr | (|faultByte[5:0]);
    always_comb begin
        next_spiErr = spiErr;
        if (frameErr) begin
            next_spiErr = 1'b1;
        end else if (clrReq && chipSelectPin_n) begin
            next_spiErr = 1'b0;
        end
        next_faultDrive = faultAny;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            spiErr     <= 1'b0;
            faultDrive <= 1'b0;
        end else if (ce) begin
            spiErr     <= next_spiErr;
            faultDrive <= next_faultDrive;
        end
    end

    // open-drain: only ever pulls low
    assign faultIndicatorPinOut_n = 1'b0;
    assign faultIndicatorPinOe    = faultDrive;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_ctrl_write;
        ce && wrHit && wrAddr == `DSC_ADDR_CTRL_FIRST && !sleepClr;
    endsequence

    // error seen, then one enabled cycle to latch it
    sequence s_err_latched;
        ce && frameErr ##1 ce;
    endsequence

    sequence s_err_held;
        ce && spiErr && !frameErr && sleepPin_n && !clrReq;
    endsequence

    property p_fault_bit_pin;
        faultByte[`DSC_FLT_PIN] != faultIndicatorPinIn_n;
    endproperty
    a_fault_bit_pin: assert property (p_fault_bit_pin)
        else $error("fault bit does not mirror pin");

    property p_err_sets_pin;
        s_err_latched |=> faultIndicatorPinOe;
    endproperty
    a_err_sets_pin: assert property (p_err_sets_pin)
        else $error("fault pin not driven after protocol error");

    property p_err_sets;
        ce && frameErr |=> spiErr;
    endproperty
    a_err_sets: assert property (p_err_sets)
        else $error("protocol error not latched");

    property p_err_pin;
        ce && spiErr |=> faultIndicatorPinOe;
    endproperty
    a_err_pin: assert property (p_err_pin)
        else $error("fault pin not driven for protocol error");

    property p_err_holds;
        s_err_held |=> spiErr;
    endproperty
    a_err_holds: assert property (p_err_holds)
        else $error("protocol error cleared without request");

    property p_undervoltage;
        ce && sleepPin_n |=> faultByte[`DSC_FLT_UV] ==
            $past(diag.supplyUndervoltageFlag) &&
            faultByte[`DSC_FLT_PUMP_UNDERVOLTAGE_FLAG] == $past(diag.pumpUndervoltageFlag);
    endproperty
    a_undervoltage: assert property (p_undervoltage)
        else $error("undervoltage bits do not follow detectors");

    property p_overcurrent_any;
        ce && sleepPin_n |=> faultByte[`DSC_FLT_OCP] ==
            (|$past(diag.bridgeOvercurrent));
    endproperty
    a_overcurrent_any: assert property (p_overcurrent_any)
        else $error("overcurrent summary wrong");

    property p_thermal_or;
        ce && sleepPin_n |=> faultByte[`DSC_FLT_TF] ==
            ($past(diag.undertempWarningFlag) |
             $past(diag.overtempWarningFlag) |
             $past(diag.overtempShutdownFlag));
    endproperty
    a_thermal_or: assert property (p_thermal_or)
        else $error("thermal summary is not the OR of its flags");

    property p_reserved_zero;
        diag2Byte[`DSC_D2_RSVD] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved detail bit not zero");

    property p_ctrl_write;
        s_ctrl_write |=> ctrlVal[0] == $past(wrData);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("torque and slew byte not written");

    property p_sleep_default;
        ce && sleepClr && !frameErr && chipSelectPin_n |=>
            ctrlVal[0] == `DSC_RST_TORQUE_SLEW && !spiErr && stat == '0;
    endproperty
    a_sleep_default: assert property (p_sleep_default)
        else $error("sleep pulse did not restore defaults");

endmodule

// ---- dv/dsc_spi_host.sv ----
/*
 * Host model for the serial port: plays whole frames of a chosen
 * sclk rise count and collects what the device shifts back.
 * Assumes pins sampled on ref_clk and sclk idling low.
 */
`timescale 1ns/100ps
module dsc_spi_host (
    input  wire logic ref_clk,
    output logic      chipSelectPin_n,
    output logic      sclkPin,
    output logic      sdiPin,
    input  wire logic sdoPin
);
    // idle pins at time zero
    initial begin
        chipSelectPin_n = 1'b1;
        sclkPin = 1'b0;
        sdiPin = 1'b0;
    end

    // one frame; 0 rises is empty, beyond 16 shifts zeros
    task automatic xfer(input logic [15:0] word, input int rises,
                        output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge ref_clk);
        chipSelectPin_n <= 1'b0;
        for (int i = 0; i < rises; i++) begin
            sdiPin <= (i < 16) ? word[15 - i] : 1'b0;
            // low 3 cycles so the device's sdo step has landed
            repeat (3) @(posedge ref_clk);
            if (i < 16) rx[15 - i] = sdoPin;
            sclkPin <= 1'b1;
            repeat (2) @(posedge ref_clk);
            sclkPin <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
        chipSelectPin_n <= 1'b1;
        sdiPin <= ~sdiPin; // idle line left at the inverse of the last bit sent
        repeat (5) @(posedge ref_clk);
    endtask

    // writes only go to the status and control map
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        logic [15:0] rx;
        xfer({2'b00, addr, 1'b0, data}, 16, rx);
    endtask

    // report byte is the addressed register
    task automatic rd(input logic [4:0] addr, output logic [7:0] data);
        logic [15:0] rx;
        xfer({2'b01, addr, 9'h000}, 16, rx);
        data = rx[7:0];
    endtask
endmodule

// ---- dv/dsc_regs_bench.sv ----
/*
 * Self-checking bench of the status and control register bank.
 * Assumes the consts header and package are compiled beforehand.
 */
`timescale 1ns/100ps
`include "dsc_consts.svh"
module dsc_regs_bench;
    import dsc_pkg::*;
    logic      refClk;
    logic      resetN;
    logic      sleepPinN;
    logic      csN;
    logic      sclk;
    logic      sdi;
    logic      sdo;
    logic      faultOe;
    logic      ceOn;
    logic      sdoOe;
    logic      faultOut;
    logic      extFault;
    dsc_diag_t diag;
    logic [7:0] torqueCount;
    dsc_ctrl_t ctrl;
    int        errors;
    int        samples_checked;

    // clock
    initial begin
        refClk = 1'b0;
        forever #5 refClk = ~refClk;
    end

    dsc_regs dut (
        .ref_clk(refClk), .reset_n(resetN), .ce(ceOn),
        .sleepPin_n(sleepPinN), .chipSelectPin_n(csN),
        .sclkPin(sclk), .sdiPin(sdi), .sdoPin(sdo), .sdoOe(sdoOe),
        // wired line, pulled up; extFault plays a second open drain
        .faultIndicatorPinIn_n(!((faultOe && !faultOut) || extFault)),
        .faultIndicatorPinOut_n(faultOut), .faultIndicatorPinOe(faultOe),
        .diag(diag), .torqueCountIn(torqueCount), .ctrl(ctrl)
    );

    dsc_spi_host host (
        .ref_clk(refClk), .chipSelectPin_n(csN), .sclkPin(sclk),
        .sdiPin(sdi), .sdoPin(sdo)
    );

    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("errors %0d checks %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // summary byte worked out from detector levels
    function automatic logic [7:0] expFault(dsc_diag_t d);
        logic [6:0] f;
        f = {1'b0, d.supplyUndervoltageFlag, d.pumpUndervoltageFlag,
             |d.bridgeOvercurrent, d.stallFlag,
             d.undertempWarningFlag | d.overtempWarningFlag
             | d.overtempShutdownFlag,
             d.bridgeAOpenloadFlag | d.bridgeBOpenloadFlag};
        return {|f, f};
    endfunction

    // defaults, writes to status ignored, 0x09 and unmapped reads
    task automatic check_reset;
        logic [7:0] v;
        for (int a = 0; a < 9; a++) begin
            host.rd(5'(a), v);
            check8("reset value", 8'h00, v);
        end
        host.wr(`DSC_ADDR_FAULT, 8'hff);
        host.wr(`DSC_ADDR_DIAG2, 8'hff);
        host.rd(`DSC_ADDR_FAULT, v);
        check8("status write", 8'h00, v);
        host.rd(`DSC_ADDR_DIAG2, v);
        check8("status write", 8'h00, v);
        host.rd(`DSC_ADDR_TORQUE_COUNT, v);
        check8("torque count", 8'h3c, v);
        host.rd(5'h0c, v);
        check8("unmapped read", 8'h00, v);
        check8("sdo enable idle", 8'h00, {7'h0, sdoOe});
        extFault <= 1'b1;
        repeat (2) @(posedge refClk);
        host.rd(`DSC_ADDR_FAULT, v);
        check8("wired fault", 8'h80, v);
        check8("own pull", 8'h00, {7'h0, faultOe});
        extFault <= 1'b0;
    endtask

    // one detector at a time through all three status bytes
    task automatic check_status;
        dsc_diag_t d;
        logic [7:0] v;
        logic [7:0] e;
        logic [15:0] rx;
        for (int i = 0; i < 17; i++) begin
            d = dsc_diag_t'(17'h1 << i);
            e = expFault(d);
            diag <= d;
            repeat (3) @(posedge refClk);
            host.xfer({2'b01, `DSC_ADDR_FAULT, 9'h000}, 16, rx);
            check8("status lead", {2'b11, e[5:0]}, rx[15:8]);
            check8("fault byte", e, rx[7:0]);
            check8("fault pin", {7'h0, e[7]}, {7'h0, faultOe});
            host.rd(`DSC_ADDR_OVERCURRENT, v);
            check8("overcurrent", d.bridgeOvercurrent, v);
            host.rd(`DSC_ADDR_DIAG2, v);
            check8("detail byte", {d.undertempWarningFlag,
                d.overtempWarningFlag, d.overtempShutdownFlag,
                d.stallLearningDoneFlag, d.stallFlag, 1'b0,
                d.bridgeBOpenloadFlag, d.bridgeAOpenloadFlag},
                v);
        end
        diag <= '0;
        repeat (3) @(posedge refClk);
    endtask

    // torque and slew codes, boundaries and every slew code
    task automatic check_ctrl;
        logic [7:0] vals [4] = '{8'hf0, 8'h01, 8'h5e, 8'hff};
        logic [7:0] v;
        foreach (vals[k]) begin
            host.wr(`DSC_ADDR_CTRL_FIRST, vals[k]);
            check8("torque", {4'h0, vals[k][7:4]},
                {4'h0, ctrl.torqueScaleField});
            check8("slew", {6'h0, vals[k][1:0]}, {6'h0, ctrl.slewRate});
            host.rd(`DSC_ADDR_CTRL_FIRST, v);
            check8("ctrl readback", vals[k], v);
        end
        host.wr(`DSC_ADDR_CTRL_LAST, 8'ha5);
        check8("threshold", 8'ha5, ctrl.stallThreshold);
    endtask

    // empty frame cleared by the clear bit, then overlong frame cleared by sleep
    task automatic check_proto;
        logic [15:0] rx;
        logic [7:0]  v;
        host.xfer(16'h0000, 0, rx);
        check8("error pin", 8'h01, {7'h0, faultOe && !faultOut});
        host.rd(`DSC_ADDR_FAULT, v);
        check8("empty frame", 8'hc0, v);
        host.rd(`DSC_ADDR_FAULT, v);
        check8("error held", 8'hc0, v);
        host.wr(`DSC_ADDR_PROTECTION, 8'h80);
        host.rd(`DSC_ADDR_FAULT, v);
        check8("clear bit", 8'h00, v);
        host.xfer(16'h4000, 17, rx);
        host.rd(`DSC_ADDR_FAULT, v);
        check8("long frame", 8'hc0, v);
        host.wr(`DSC_ADDR_CTRL_FIRST, 8'h5a);
        host.rd(`DSC_ADDR_CTRL_FIRST, v);
        check8("ctrl written", 8'h5a, v);
        // sleep pulse while disabled must leave everything frozen
        ceOn <= 1'b0;
        sleepPinN <= 1'b0;
        repeat (2) @(posedge refClk);
        sleepPinN <= 1'b1;
        repeat (2) @(posedge refClk);
        ceOn <= 1'b1;
        host.rd(`DSC_ADDR_FAULT, v);
        check8("frozen error", 8'hc0, v);
        host.rd(`DSC_ADDR_CTRL_FIRST, v);
        check8("frozen ctrl", 8'h5a, v);
        sleepPinN <= 1'b0;
        repeat (2) @(posedge refClk);
        sleepPinN <= 1'b1;
        repeat (2) @(posedge refClk);
        host.rd(`DSC_ADDR_FAULT, v);
        check8("sleep clear", 8'h00, v);
        host.rd(`DSC_ADDR_CTRL_FIRST, v);
        check8("sleep default", 8'h00, v);
    endtask

    // main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        resetN = 1'b0;
        sleepPinN = 1'b1;
        ceOn = 1'b1;
        extFault = 1'b0;
        diag = '0;
        torqueCount = 8'h3c;
        repeat (16) @(posedge refClk);
        resetN <= 1'b1;
        @(posedge refClk);
        check_reset();
        check_status();
        check_ctrl();
        check_proto();
        close_out();
    end
endmodule
